// *** hdl/tss_pkg.sv ***
package tss_pkg;
   //---------------------------------------------------------------
   // sizes
   //---------------------------------------------------------------
   localparam int VP_COUNT  = 4;
   localparam int VP_W      = 2;
   localparam int MAX_PTL   = 6;
   localparam int LVL_W     = 3;
   localparam int NUM_STK   = 4;
   localparam int MEM_DEPTH = VP_COUNT * MAX_PTL;
   localparam int ADDR_W    = 5;
   localparam int CAUSE_W   = 9;
   localparam int GL_W      = 3;
   localparam int CCR_W     = 8;
   localparam int ASI_W     = 8;
   localparam int CWP_W     = 3;
   localparam int PSTATE_W  = 13;
   localparam int WSEL_W    = 3;
   //---------------------------------------------------------------
   // register offsets and stack field numbers
   //---------------------------------------------------------------
   localparam logic [4:0] OFS_SAVED_PC   = 5'h00;
   localparam logic [4:0] OFS_SAVED_NPC  = 5'h01;
   localparam logic [4:0] OFS_SAVED_ST   = 5'h02;
   localparam logic [4:0] OFS_CAUSE      = 5'h03;
   localparam logic [4:0] OFS_VECTOR     = 5'h05;
   localparam int         F_PC           = 0;
   localparam int         F_NPC          = 1;
   localparam int         F_ST           = 2;
   localparam int         F_CAUSE        = 3;
   //---------------------------------------------------------------
   // saved state layout and cause field positions
   //---------------------------------------------------------------
   localparam int TS_PSTATE_LSB = 0;
   localparam int TS_CWP_LSB    = 13;
   localparam int TS_ASI_LSB    = 16;
   localparam int TS_CCR_LSB    = 24;
   localparam int TS_GL_LSB     = 32;
   localparam int CAUSE_WSEL_LSB = 2;
   localparam int WTS_NORM_LSB  = 0;
   localparam int WTS_OTHER_LSB = 3;
   //---------------------------------------------------------------
   // masks and reset values
   //---------------------------------------------------------------
   localparam logic [63:0] PC_KEEP_MASK  = 64'hffff_ffff_ffff_fffc;
   localparam logic [63:0] VEC_KEEP_MASK = 64'hffff_ffff_ffff_8000;
   localparam logic [63:0] LOW_HALF_MASK = 64'h0000_0000_ffff_ffff;
   localparam logic [63:0] NPC_STEP      = 64'h0000_0000_0000_0004;
   localparam logic [63:0] VECTOR_RESET  = 64'h0000_0000_0000_0000;
   localparam logic [LVL_W-1:0] LVL_RESET = 3'h0;
   localparam logic [LVL_W-1:0] LVL_MAX   = 3'h6;

   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b001,
      ST_READ = 3'b010,
      ST_POP  = 3'b100
   } tss_state_type;
endpackage

// *** hdl/tss_stack_if.sv ***
`timescale 1ns/1ps
// write and read port of the four trap-state stacks
interface tss_stack_if;
   import tss_pkg::*;
   logic [NUM_STK-1:0] we;
   logic [ADDR_W-1:0]  waddr;
   logic [63:0]        wdata [NUM_STK];
   logic [ADDR_W-1:0]  raddr;
   logic [63:0]        rdata [NUM_STK];
   modport ctrl (output we, waddr, wdata, raddr, input rdata);
   modport mem  (input we, waddr, wdata, raddr, output rdata);
endinterface

// *** hdl/tss_stack_mem.sv ***
`timescale 1ns/1ps
module tss_stack_mem
   import tss_pkg::*;
(
   input wire logic  i_clk,
   input wire logic  i_resetn,
   tss_stack_if.mem  bus
);
   // no reset on the array: entries above the level are undefined anyway
   logic [63:0] mem [NUM_STK][MEM_DEPTH];

   // per-field write, shared address
   always_ff @(posedge i_clk)
   begin
      for (int f = 0; f < NUM_STK; f++)
      begin
         if (bus.we[f])
            mem[f][bus.waddr] <= bus.wdata[f];
      end
   end

   // registered read data, one cycle after the address
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         for (int f = 0; f < NUM_STK; f++)
            bus.rdata[f] <= 64'h0;
      else
         for (int f = 0; f < NUM_STK; f++)
            bus.rdata[f] <= mem[f][bus.raddr];
   end

   chk_mem_readback: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      bus.we[F_CAUSE] ##1
      (bus.raddr == $past(bus.waddr) && !bus.we[F_CAUSE])
      |=> bus.rdata[F_CAUSE] == $past(bus.wdata[F_CAUSE], 2))
      else $error("cause stack readback mismatch");
endmodule

// *** hdl/tss_access_check.sv ***
`timescale 1ns/1ps
module tss_access_check
   import tss_pkg::*;
(
   input  wire logic       i_request,
   input  wire logic       i_priv,
   input  wire logic [4:0] i_reg,
   input  wire logic       i_level_zero,
   output logic            o_violation,
   output logic            o_illegal,
   output logic            o_is_stack,
   output logic            o_is_vector
);
   // offsets 0..3 are the stacks, 5 is the vector base
   assign o_is_stack  = (i_reg <= OFS_CAUSE);
   assign o_is_vector = (i_reg == OFS_VECTOR);
   // nonprivileged access never reaches a register
   assign o_violation = i_request && !i_priv;
   // a stack offset at level zero or an unmapped offset is an illegal instruction
   assign o_illegal = i_request && i_priv &&
                      ((o_is_stack && i_level_zero) ||
                       !(o_is_stack || o_is_vector));
endmodule

// *** hdl/tss_top.sv ***
`timescale 1ns/1ps
module tss_top
   import tss_pkg::*;
(
   input  wire logic                i_clk,
   input  wire logic                i_resetn,
   input  wire logic [VP_W-1:0]     i_vp,
   input  wire logic                i_priv_flag,
   input  wire logic                i_address_mask_flag,
   input  wire logic                i_op_valid,
   input  wire logic                i_op_write,
   input  wire logic [4:0]          i_op_reg,
   input  wire logic [63:0]         i_op_wdata,
   input  wire logic                i_trap_valid,
   input  wire logic [CAUSE_W-1:0]  i_trap_type,
   input  wire logic                i_trap_window,
   input  wire logic [63:0]         i_cur_pc,
   input  wire logic [63:0]         i_cur_npc,
   input  wire logic [GL_W-1:0]     i_global_level,
   input  wire logic [CCR_W-1:0]    i_condition_codes_reg,
   input  wire logic [ASI_W-1:0]    i_address_space_id,
   input  wire logic [CWP_W-1:0]    i_current_window_pointer,
   input  wire logic [PSTATE_W-1:0] i_pstate,
   input  wire logic [5:0]          i_window_trap_select,
   input  wire logic [2:0]          i_other_windows_count,
   input  wire logic                i_ret_valid,
   input  wire logic                i_ret_is_done,
   output logic                     o_ready,
   output logic                     o_op_done,
   output logic [63:0]              o_op_rdata,
   output logic                     o_priv_violation,
   output logic                     o_illegal_instr,
   output logic                     o_trap_ack,
   output logic                     o_ret_valid,
   output logic [63:0]              o_new_pc,
   output logic [63:0]              o_new_npc,
   output logic [GL_W-1:0]          o_restore_gl,
   output logic [CCR_W-1:0]         o_restore_ccr,
   output logic [ASI_W-1:0]         o_restore_asi,
   output logic [CWP_W-1:0]         o_restore_cwp,
   output logic [PSTATE_W-1:0]      o_restore_pstate,
   output logic [LVL_W-1:0]         o_trap_nesting_level,
   output logic [63:0]              o_trap_vector_base
);
   //---------------------------------------------------------------
   // declarations
   //---------------------------------------------------------------
   tss_state_type    state;
   logic [LVL_W-1:0] level [VP_COUNT];
   logic [63:0]      vector [VP_COUNT];
   logic [LVL_W-1:0] cur_level;
   logic             idle;
   logic             acc_trap;
   logic             acc_ret;
   logic             acc_op;
   logic             push_ok;
   logic             ret_ok;
   logic             op_ok;
   logic             violation;
   logic             illegal;
   logic             is_stack;
   logic             is_vector;
   logic [VP_W-1:0]  hold_vp;
   logic [4:0]       hold_reg;
   logic             hold_done;
   logic [63:0]      trap_pc;
   logic [63:0]      trap_npc;
   logic [63:0]      trap_cause;
   logic [63:0]      trap_state;
   logic [LVL_W-1:0] slot;

   tss_stack_if stk ();

   // stack slot of (processor, entry); entry k lives at slot k-1
   function automatic logic [ADDR_W-1:0] stack_addr
      (input logic [VP_W-1:0] vp, input logic [LVL_W-1:0] idx);
      logic [ADDR_W-1:0] base;
      base = ADDR_W'(vp) * ADDR_W'(MAX_PTL);
      return base + ADDR_W'(idx);
   endfunction

   //---------------------------------------------------------------
   // request arbitration: trap, then return, then register access
   //---------------------------------------------------------------
   assign idle      = (state == ST_IDLE);
   assign o_ready   = idle;
   assign cur_level = level[i_vp];
   assign acc_trap  = idle && i_trap_valid;
   assign acc_ret   = idle && !i_trap_valid && i_ret_valid;
   assign acc_op    = idle && !i_trap_valid && !i_ret_valid && i_op_valid;
   // a trap with the stack full is dropped rather than overwrite entries
   assign push_ok   = acc_trap && (cur_level < LVL_MAX);
   assign ret_ok    = acc_ret && (cur_level != LVL_RESET);
   assign op_ok     = acc_op && !violation && !illegal;

   tss_access_check u_check
   (
      .i_request    (acc_op),
      .i_priv       (i_priv_flag),
      .i_reg        (i_op_reg),
      .i_level_zero (cur_level == LVL_RESET),
      .o_violation  (violation),
      .o_illegal    (illegal),
      .o_is_stack   (is_stack),
      .o_is_vector  (is_vector)
   );

   //---------------------------------------------------------------
   // trap push data
   //---------------------------------------------------------------
   always_comb
   begin
      trap_pc  = i_cur_pc;
      trap_npc = i_cur_npc;
      if (i_address_mask_flag)
      begin
         trap_pc  = i_cur_pc & LOW_HALF_MASK;
         trap_npc = i_cur_npc & LOW_HALF_MASK;
      end
      trap_pc  = trap_pc & PC_KEEP_MASK;
      trap_npc = trap_npc & PC_KEEP_MASK;
      trap_cause = 64'(i_trap_type);
      if (i_trap_window)
      begin
         if (i_other_windows_count != 3'h0)
            trap_cause[CAUSE_WSEL_LSB +: WSEL_W] =
               i_window_trap_select[WTS_OTHER_LSB +: WSEL_W];
         else
            trap_cause[CAUSE_WSEL_LSB +: WSEL_W] =
               i_window_trap_select[WTS_NORM_LSB +: WSEL_W];
      end
      trap_state = 64'h0;
      trap_state[TS_PSTATE_LSB +: PSTATE_W] = i_pstate;
      trap_state[TS_CWP_LSB +: CWP_W] = i_current_window_pointer;
      trap_state[TS_ASI_LSB +: ASI_W] = i_address_space_id;
      trap_state[TS_CCR_LSB +: CCR_W] = i_condition_codes_reg;
      trap_state[TS_GL_LSB +: GL_W]   = i_global_level;
   end

   //---------------------------------------------------------------
   // stack port: push writes entry n+1, everything else uses entry n
   //---------------------------------------------------------------
   assign slot = push_ok ? cur_level : cur_level - LVL_W'(1);
   always_comb
   begin
      stk.we    = '0;
      stk.waddr = stack_addr(i_vp, slot);
      stk.raddr = stack_addr(i_vp, slot);
      for (int f = 0; f < NUM_STK; f++)
         stk.wdata[f] = i_op_wdata;
      if (push_ok)
      begin
         stk.we             = '1;
         stk.wdata[F_PC]    = trap_pc;
         stk.wdata[F_NPC]   = trap_npc;
         stk.wdata[F_ST]    = trap_state;
         stk.wdata[F_CAUSE] = trap_cause;
      end
      else if (op_ok && i_op_write && is_stack)
      begin
         stk.we[i_op_reg[1:0]] = 1'b1;
         if (i_op_reg[4:1] == 4'h0)
            stk.wdata[i_op_reg[1:0]] = i_op_wdata & PC_KEEP_MASK;
      end
   end

   tss_stack_mem u_mem
   (
      .i_clk    (i_clk),
      .i_resetn (i_resetn),
      .bus      (stk.mem)
   );

   //---------------------------------------------------------------
   // sequencer: reads and pops wait one cycle for the array
   //---------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         state <= ST_IDLE;
      else
         case (state)
            ST_IDLE:
               if (ret_ok)
                  state <= ST_POP;
               else if (op_ok && !i_op_write)
                  state <= ST_READ;
            ST_READ: state <= ST_IDLE;
            ST_POP:  state <= ST_IDLE;
            default: state <= ST_IDLE;
         endcase
   end

   // request context held through the array read
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         hold_vp   <= '0;
         hold_reg  <= OFS_SAVED_PC;
         hold_done <= 1'b0;
      end
      else if (idle)
      begin
         hold_vp   <= i_vp;
         hold_reg  <= i_op_reg;
         hold_done <= i_ret_is_done;
      end
   end

   //---------------------------------------------------------------
   // per-processor nesting level and vector base
   //---------------------------------------------------------------
   for (genvar g = 0; g < VP_COUNT; g++)
   begin : g_vp
      always_ff @(posedge i_clk or negedge i_resetn)
      begin
         if (!i_resetn)
            level[g] <= LVL_RESET;
         else if (push_ok && i_vp == VP_W'(g))
            level[g] <= level[g] + LVL_W'(1);
         else if (state == ST_POP && hold_vp == VP_W'(g))
            level[g] <= level[g] - LVL_W'(1);
      end

      // low bits are cut on write, so reads see zero there
      always_ff @(posedge i_clk or negedge i_resetn)
      begin
         if (!i_resetn)
            vector[g] <= VECTOR_RESET;
         else if (op_ok && i_op_write && is_vector && i_vp == VP_W'(g))
            vector[g] <= i_op_wdata & VEC_KEEP_MASK;
      end
   end

   // level and vector base of the selected processor, one cycle late
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_trap_nesting_level <= LVL_RESET;
         o_trap_vector_base   <= VECTOR_RESET;
      end
      else
      begin
         o_trap_nesting_level <= level[i_vp];
         o_trap_vector_base   <= vector[i_vp];
      end
   end

   //---------------------------------------------------------------
   // answers to the pipeline
   //---------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_op_done        <= 1'b0;
         o_op_rdata       <= 64'h0;
         o_priv_violation <= 1'b0;
         o_illegal_instr  <= 1'b0;
         o_trap_ack       <= 1'b0;
      end
      else
      begin
         o_priv_violation <= violation;
         o_illegal_instr  <= illegal || (acc_ret && !ret_ok);
         o_trap_ack       <= push_ok;
         o_op_done        <= (op_ok && i_op_write) || state == ST_READ;
         if (state == ST_READ)
            o_op_rdata <= (hold_reg == OFS_VECTOR) ? vector[hold_vp]
                        : stk.rdata[hold_reg[1:0]];
      end
   end

   // pop: retry resumes at saved pc, done skips to saved next pc
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_ret_valid      <= 1'b0;
         o_new_pc         <= 64'h0;
         o_new_npc        <= 64'h0;
         o_restore_gl     <= '0;
         o_restore_ccr    <= '0;
         o_restore_asi    <= '0;
         o_restore_cwp    <= '0;
         o_restore_pstate <= '0;
      end
      else
      begin
         o_ret_valid <= (state == ST_POP);
         if (state == ST_POP)
         begin
            if (hold_done)
            begin
               o_new_pc  <= stk.rdata[F_NPC];
               o_new_npc <= stk.rdata[F_NPC] + NPC_STEP;
            end
            else
            begin
               o_new_pc  <= stk.rdata[F_PC];
               o_new_npc <= stk.rdata[F_NPC];
            end
            o_restore_gl     <= stk.rdata[F_ST][TS_GL_LSB +: GL_W];
            o_restore_ccr    <= stk.rdata[F_ST][TS_CCR_LSB +: CCR_W];
            o_restore_asi    <= stk.rdata[F_ST][TS_ASI_LSB +: ASI_W];
            o_restore_cwp    <= stk.rdata[F_ST][TS_CWP_LSB +: CWP_W];
            o_restore_pstate <= stk.rdata[F_ST][TS_PSTATE_LSB +: PSTATE_W];
         end
      end
   end

   //---------------------------------------------------------------
   // checks
   //---------------------------------------------------------------
   chk_priv_block: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      acc_op && !i_priv_flag |-> stk.we == '0 ##1
      (o_priv_violation && !o_op_done))
      else $error("nonprivileged access was not refused");

   chk_level_zero: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      acc_op && i_priv_flag && i_op_reg <= OFS_CAUSE && cur_level == 3'h0
      |=> o_illegal_instr && !o_op_done)
      else $error("stack access at level zero not illegal");

   chk_level_push: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      push_ok |=> level[$past(i_vp)] == $past(cur_level) + 3'h1)
      else $error("trap did not raise the nesting level");

   chk_ret_timing: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      ret_ok |=> !o_ret_valid && !o_ready ##1 o_ret_valid && o_ready)
      else $error("return answer not two cycles after request");

   chk_done_npc: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      o_ret_valid && hold_done |-> o_new_npc == o_new_pc + NPC_STEP)
      else $error("done next pc is not pc plus four");

   chk_pc_align: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      o_ret_valid |-> o_new_pc[1:0] == 2'h0 && o_new_npc[1:0] == 2'h0)
      else $error("restored pc has low bits set");

   chk_vector_low: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      o_trap_vector_base[14:0] == 15'h0)
      else $error("vector base low bits not zero");

   chk_am_mask: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      push_ok && i_address_mask_flag |->
      stk.wdata[F_PC][63:32] == 32'h0 && stk.wdata[F_NPC][63:32] == 32'h0)
      else $error("masked trap saved upper pc bits");

   chk_window_sel: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      push_ok && i_trap_window && i_other_windows_count != 3'h0 |->
      stk.wdata[F_CAUSE][4:2] == i_window_trap_select[5:3])
      else $error("window trap did not use the other select set");
endmodule

// *** tb/tss_pipe_model.sv ***
`timescale 1ns/1ps
// --------------------------------------------------------------
// pipeline side: architectural pc, next pc and state words
// --------------------------------------------------------------
module tss_pipe_model
   import tss_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_load,
   input  wire logic [63:0] i_pc,
   input  wire logic        i_ret,
   input  wire logic [63:0] i_ret_pc,
   input  wire logic [63:0] i_ret_npc,
   output logic [63:0]      o_pc,
   output logic [63:0]      o_npc,
   output logic [34:0]      o_state
);
   // a return redirects fetch, so it wins over a plain load
   always_ff @(posedge i_clk)
   begin
      if (i_ret)
      begin
         o_pc  <= i_ret_pc;
         o_npc <= i_ret_npc;
      end
      else if (i_load)
      begin
         o_pc  <= i_pc;
         o_npc <= i_pc + 64'h4;
      end
   end
   // state words follow pc so pushes at different pcs carry distinct patterns
   assign o_state = o_pc[36:2];
endmodule

// *** tb/tss_top_test.sv ***
`timescale 1ns/1ps
module tss_top_test;
   import tss_pkg::*;
   localparam logic [63:0] P1 = 64'h1234_5678_9abc_def3;
   localparam logic [63:0] P2 = 64'hfedc_ba98_7654_3211;
   localparam logic [63:0] P3 = 64'h0f0f_0f0f_0f0f_0f0e;
   localparam int          RD = 0, TRP = 1, RET = 2, WR = 3;
   logic                i_clk, i_resetn, i_priv_flag, i_address_mask_flag;
   logic                i_op_valid, i_op_write, i_trap_valid, i_trap_window;
   logic                i_ret_valid, i_ret_is_done, load, o_ready, o_op_done;
   logic                o_priv_violation, o_illegal_instr, o_trap_ack;
   logic                o_ret_valid;
   logic [VP_W-1:0]     i_vp;
   logic [4:0]          i_op_reg, res;
   logic [CAUSE_W-1:0]  i_trap_type;
   logic [5:0]          i_window_trap_select;
   logic [2:0]          i_other_windows_count;
   logic [63:0]         i_op_wdata, ld_pc, o_op_rdata, o_new_pc, o_new_npc;
   logic [63:0]         o_trap_vector_base;
   wire  [63:0]         i_cur_pc, i_cur_npc;
   wire  [34:0]         st;
   wire  [GL_W-1:0]     i_global_level;
   wire  [CCR_W-1:0]    i_condition_codes_reg;
   wire  [ASI_W-1:0]    i_address_space_id;
   wire  [CWP_W-1:0]    i_current_window_pointer;
   wire  [PSTATE_W-1:0] i_pstate;
   logic [GL_W-1:0]     o_restore_gl;
   logic [CCR_W-1:0]    o_restore_ccr;
   logic [ASI_W-1:0]    o_restore_asi;
   logic [CWP_W-1:0]    o_restore_cwp;
   logic [PSTATE_W-1:0] o_restore_pstate;
   logic [LVL_W-1:0]    o_trap_nesting_level;
   int                  mismatches, n_checks, cycles;

   tss_top DUT (.*);
   tss_pipe_model PIPE (.i_clk(i_clk), .i_load(load), .i_pc(ld_pc),
      .i_ret(o_ret_valid), .i_ret_pc(o_new_pc), .i_ret_npc(o_new_npc),
      .o_pc(i_cur_pc), .o_npc(i_cur_npc), .o_state(st));
   assign {i_global_level, i_condition_codes_reg, i_address_space_id,
           i_current_window_pointer, i_pstate} = st;

   // --------------------------------------------------------------
   // clock, cycle ceiling and closing report
   // --------------------------------------------------------------
   initial
   begin
      i_clk = 1'b0;
      forever #2.5 i_clk = ~i_clk;
   end
   task automatic results;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // the whole script needs just under a hundred cycles
   always @(posedge i_clk)
   begin
      cycles = cycles + 1;
      if (cycles == 3000)
      begin
         mismatches = mismatches + 1;
         results();
      end
   end

   // --------------------------------------------------------------
   // request and compare tasks
   // --------------------------------------------------------------
   task automatic chk(input string nm, input logic [63:0] e, g);
      n_checks = n_checks + 1;
      if (g !== e)
      begin
         mismatches = mismatches + 1;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one request held for the taking edge, then up to four answer slots
   task automatic go(input int kind, input logic [4:0] r,
                     input logic [63:0] d);
      int k;
      @(posedge i_clk);
      i_op_valid    <= (kind == RD) || (kind == WR);
      i_op_write    <= (kind == WR);
      i_trap_valid  <= (kind == TRP);
      i_ret_valid   <= (kind == RET);
      i_op_reg      <= r;
      i_op_wdata    <= d;
      i_trap_type   <= d[8:0];
      i_trap_window <= d[9];
      i_ret_is_done <= d[0];
      @(posedge i_clk);
      {i_op_valid, i_trap_valid, i_ret_valid} <= 3'h0;
      res = 5'h00;
      // the first answer slot is just after the taking edge
      for (k = 0; k < 4 && res === 5'h00; k++)
      begin
         if (k > 0)
            @(posedge i_clk);
         #1 res = {o_op_done, o_priv_violation, o_illegal_instr,
                   o_trap_ack, o_ret_valid};
      end
   endtask
   task automatic rdc(input logic [4:0] r, input logic [63:0] e);
      go(RD, r, 64'h0);
      chk("read data", e, o_op_rdata);
   endtask
   task automatic setpc(input logic [63:0] p);
      @(posedge i_clk);
      ld_pc <= p;
      load  <= 1'b1;
      @(posedge i_clk);
      load  <= 1'b0;
   endtask

   // --------------------------------------------------------------
   // test script
   // --------------------------------------------------------------
   initial
   begin
      {i_resetn, i_priv_flag, i_address_mask_flag, i_op_valid} = 4'h0;
      {i_op_write, i_trap_valid, i_trap_window, i_ret_valid} = 4'h0;
      {i_ret_is_done, load, i_vp, i_op_reg, i_trap_type} = 18'h0;
      {i_other_windows_count, i_window_trap_select} = 9'h02a;
      {i_op_wdata, ld_pc} = 128'h0;
      {mismatches, n_checks, cycles} = 96'h0;
      repeat (12) @(posedge i_clk);
      i_resetn <= 1'b1;
      // refusals and the vector base
      go(WR, OFS_VECTOR, 64'h1);
      chk("violation", 5'h08, res);
      @(posedge i_clk) i_priv_flag <= 1'b1;
      go(RD, OFS_SAVED_PC, 64'h0);
      chk("level zero", 5'h04, res);
      go(WR, 5'h04, 64'h0);
      chk("unmapped", 5'h04, res);
      go(WR, OFS_VECTOR, 64'hffff_ffff_ffff_ffff);
      rdc(OFS_VECTOR, 64'hffff_ffff_ffff_8000);
      chk("vector out", 64'hffff_ffff_ffff_8000, o_trap_vector_base);
      $display("test refusals end");
      // three nested traps, the last two for windows
      setpc(P1);
      go(TRP, 5'h0, 64'h0a5);
      chk("ack", 5'h02, res);
      // the level output trails the level by one cycle
      @(posedge i_clk) #1 chk("level", 64'h1, o_trap_nesting_level);
      rdc(OFS_SAVED_PC, 64'h1234_5678_9abc_def0);
      rdc(OFS_SAVED_NPC, 64'h1234_5678_9abc_def4);
      rdc(OFS_SAVED_ST, {29'h0, P1[36:2]});
      rdc(OFS_CAUSE, 64'h0a5);
      setpc(P2);
      @(posedge i_clk) i_address_mask_flag <= 1'b1;
      go(TRP, 5'h0, 64'h280);
      rdc(OFS_SAVED_PC, 64'h0000_0000_7654_3210);
      rdc(OFS_CAUSE, 64'h088);
      setpc(P3);
      @(posedge i_clk) {i_address_mask_flag, i_other_windows_count} <= 4'h2;
      go(TRP, 5'h0, 64'h280);
      rdc(OFS_CAUSE, 64'h094);
      go(WR, OFS_SAVED_NPC, 64'hffff_ffff_ffff_ffff);
      rdc(OFS_SAVED_NPC, 64'hffff_ffff_ffff_fffc);
      $display("test trap push end");
      // retry at level 3, then done at level 2
      go(RET, 5'h0, 64'h0);
      chk("retry pc", 64'h0f0f_0f0f_0f0f_0f0c, o_new_pc);
      chk("retry npc", 64'hffff_ffff_ffff_fffc, o_new_npc);
      chk("retry state", {29'h0, P3[36:2]}, {o_restore_gl, o_restore_ccr,
          o_restore_asi, o_restore_cwp, o_restore_pstate});
      go(RET, 5'h0, 64'h1);
      chk("done pc", 64'h0000_0000_7654_3214, o_new_pc);
      chk("done npc", 64'h0000_0000_7654_3218, o_new_npc);
      chk("done state", {29'h0, P2[36:2]}, {o_restore_gl, o_restore_ccr,
          o_restore_asi, o_restore_cwp, o_restore_pstate});
      @(posedge i_clk) #1 chk("level", 64'h1, o_trap_nesting_level);
      rdc(OFS_CAUSE, 64'h0a5);
      $display("test returns end");
      // another processor starts at level zero
      @(posedge i_clk) i_vp <= 2'h1;
      go(RD, OFS_CAUSE, 64'h0);
      chk("other vp", 5'h04, res);
      go(RET, 5'h0, 64'h0);
      chk("empty return", 5'h04, res);
      @(posedge i_clk) i_vp <= 2'h0;
      // fill the stack to its top, then one trap too many
      repeat (5) go(TRP, 5'h0, 64'h001);
      @(posedge i_clk) #1 chk("top level", 64'h6, o_trap_nesting_level);
      go(TRP, 5'h0, 64'h001);
      chk("full drop", 5'h00, res);
      $display("test stack depth end");
      results();
   end
endmodule
